// file: src/fcs_consts.svh
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// Option block in flash, word addressed.
`define FCS_OPT_BASE      22'h008000
`define FCS_OPT_WORDS     32
`define FCS_OPT_AW        5

// Option word 0 fields.
`define FCS_OPT_SCHEME_LSB 0
`define FCS_OPT_DECOMP_BIT 3
`define FCS_OPT_DIV_LSB    4
// Page start and length words are scaled by this shift.
`define FCS_PAGE_SHIFT     6

// Clock rates.
`define FCS_CLK_MHZ       40
`define FCS_OSC_MHZ       10
`define FCS_FETCH_DIV     (`FCS_CLK_MHZ / `FCS_OSC_MHZ)

// Done timeout in configuration clock edges.
`define FCS_DONE_EDGES    64

// Pulse lengths, least times rounded up.
`define FCS_ERR_PULSE_NS  1000
`define FCS_ERR_PULSE_CYC ((`FCS_ERR_PULSE_NS * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_RECONF_NS     2000
`define FCS_RECONF_CYC    ((`FCS_RECONF_NS * `FCS_CLK_MHZ + 999) / 1000)

// Reset values.
`define FCS_RST_DATA      8'h00

`endif

// file: src/fcs_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fcs_mem_if;
   logic        we;
   logic [4:0]  waddr;
   logic [15:0] wdata;
   logic [4:0]  raddr;
   logic [15:0] rdata;

   modport ctl (output we, waddr, wdata, raddr, input rdata);
   modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface // fcs_mem_if

`default_nettype wire

// file: src/fcs_opt_mem.sv
`timescale 1ns/1ps
`default_nettype none

module fcs_opt_mem (
   // Clock
   input  wire logic clk_in,
   // Access port
   fcs_mem_if.mem    port
);

   logic [15:0] mem_q [0:31];

   always_ff @(posedge clk_in) begin
      if (port.we) begin
         mem_q[port.waddr] <= port.wdata;
      end
      port.rdata <= mem_q[port.raddr];
   end

endmodule // fcs_opt_mem

`default_nettype wire

// file: src/fcs_pkg.sv
package fcs_pkg;

   typedef enum logic [2:0] {
      FCS_S_HOLD     = 3'b000,
      FCS_S_FETCH    = 3'b001,
      FCS_S_APPLY    = 3'b010,
      FCS_S_READY    = 3'b011,
      FCS_S_STREAM   = 3'b100,
      FCS_S_DONEW    = 3'b101,
      FCS_S_ERR      = 3'b110,
      FCS_S_COMPLETE = 3'b111
   } fcs_state_e;

   typedef enum logic [2:0] {
      FCS_M_SER1 = 3'b000,
      FCS_M_SER2 = 3'b001,
      FCS_M_SER4 = 3'b010,
      FCS_M_SER8 = 3'b011,
      FCS_M_BYTE = 3'b100
   } fcs_scheme_e;

   typedef struct packed {
      fcs_state_e  state;
      logic        st1;
      logic        st2;
      logic        dn1;
      logic        dn2;
      logic [2:0]  pg1;
      logic [2:0]  pg2;
      logic [2:0]  tick;
      logic [5:0]  widx;
      logic        pend;
      logic        rd;
      logic [21:0] fa;
      logic [21:0] nxt;
      logic [21:0] left;
      logic [2:0]  scheme;
      logic        decomp;
      logic [7:0]  div;
      logic [2:0]  page;
      logic [15:0] sh;
      logic [4:0]  bits;
      logic        dat_ok;
      logic        last_seen;
      logic [7:0]  dat;
      logic        clk_o;
      logic [7:0]  hcnt;
      logic [6:0]  edges;
      logic [7:0]  pc;
      logic [7:0]  rc;
      logic        din_v;
      logic [15:0] din_w;
   } fcs_st_s;

endpackage

// file: src/fcs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcs_consts.svh"

// Notes on behaviour
// - After reset read 32 option words from flash word address 0x8000.
// - Option fetch paced at the 10 MHz default oscillator rate.
// - Options set scheme, clock divider, decompression and page placement.
// - Start clock and data only when status high and done low.
// - Page select pins sampled after reset and held for the transfer.
// - Serial chain mode sends 1, 2, 4 or 8 bits per clock.
// - Byte parallel mode sends a whole byte per clock.
// - Data lines outside the selected width are driven low.
// - Clock stops while no data is ready and resumes after.
// - Done error if done stays low 64 clocks after the last bit.
// - Done error pulses the status pin low to restart configuration.
// - Status pulled low by the target halts the transfer.
// - Status released again lets the controller retry configuration.
// - After completion clock held low and all data lines high.
// - After completion flash path floats with pull-ups and keepers.
// - Reconfiguration request pin pulled low on the initiate instruction.
// - Status line open drain, only ever pulled low, never driven high.
// - Low pulse on status restarts the controller from the beginning.
// - Flash words optionally decompressed, streamed out in real time.
module fcs_top (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // Internal flash read path
   output logic [21:0]      flash_addr_out,
   output logic             flash_rd_out,
   input  wire logic [15:0] flash_data_in,
   input  wire logic        flash_valid_in,
   output logic             flash_drive_out,
   output logic             flash_pullup_out,
   output logic             flash_keeper_out,
   // Decompressor
   output logic             dec_in_valid_out,
   output logic [15:0]      dec_in_word_out,
   input  wire logic        dec_in_ready_in,
   input  wire logic        dec_out_valid_in,
   input  wire logic [15:0] dec_out_word_in,
   input  wire logic        dec_out_last_in,
   output logic             dec_out_ready_out,
   // Target configuration pins
   output logic             config_clock_out,
   output logic [7:0]       config_data_out,
   output logic             byte_parallel_mode_out,
   input  wire logic        status_in,
   output logic             status_out,
   output logic             status_oe_out,
   input  wire logic        done_in,
   input  wire logic [2:0]  page_select_in,
   // Reconfiguration request
   input  wire logic        init_conf_in,
   output logic             reconf_req_out,
   output logic             reconf_req_oe_out
);

   localparam fcs_pkg::fcs_st_s ST_RST = '{
      state : fcs_pkg::FCS_S_FETCH,
      st1   : 1'b1,
      st2   : 1'b1,
      dat   : `FCS_RST_DATA,
      default : '0
   };

   fcs_pkg::fcs_st_s st_q;
   fcs_pkg::fcs_st_s st_d;

   logic             can_rd;
   logic             fin;
   logic             dec_take;

   fcs_mem_if mi ();

   fcs_opt_mem u_mem (
      .clk_in (clk_in),
      .port   (mi.mem)
   );

   // Number of data lines in use for a scheme.
   function automatic logic [4:0] lane_width(input logic [2:0] s);
      unique case (s)
         fcs_pkg::FCS_M_SER1: lane_width = 5'h01;
         fcs_pkg::FCS_M_SER2: lane_width = 5'h02;
         fcs_pkg::FCS_M_SER4: lane_width = 5'h04;
         default:             lane_width = 5'h08;
      endcase
   endfunction

   // Mask that keeps unused data lines low.
   function automatic logic [7:0] lane_mask(input logic [2:0] s);
      unique case (s)
         fcs_pkg::FCS_M_SER1: lane_mask = 8'h01;
         fcs_pkg::FCS_M_SER2: lane_mask = 8'h03;
         fcs_pkg::FCS_M_SER4: lane_mask = 8'h0f;
         default:             lane_mask = 8'hff;
      endcase
   endfunction

   // Option memory word read at each apply step.
   function automatic logic [4:0] opt_addr(input logic [5:0] idx,
                                           input logic [2:0] pg);
      unique case (idx[1:0])
         2'b00:   opt_addr = 5'h00;
         2'b01:   opt_addr = {1'b0, pg, 1'b0} + 5'h01;
         default: opt_addr = {1'b0, pg, 1'b0} + 5'h02;
      endcase
   endfunction

   assign mi.we    = (st_q.state == fcs_pkg::FCS_S_FETCH)
                     && st_q.pend && flash_valid_in;
   assign mi.waddr = st_q.widx[4:0];
   assign mi.wdata = flash_data_in;
   assign mi.raddr = opt_addr(st_q.widx, st_q.page);

   assign dec_take = (st_q.state == fcs_pkg::FCS_S_STREAM)
                     && st_q.decomp && (st_q.bits == 5'h00);

   assign can_rd = (st_q.left != 22'h0) && !st_q.pend
                   && (st_q.decomp ? !st_q.din_v : (st_q.bits == 5'h00));

   assign fin = st_q.decomp ? st_q.last_seen
                            : ((st_q.left == 22'h0) && !st_q.pend);

   always_comb begin
      st_d     = st_q;
      st_d.rd  = 1'b0;
      st_d.st1 = status_in;
      st_d.st2 = st_q.st1;
      st_d.dn1 = done_in;
      st_d.dn2 = st_q.dn1;
      st_d.pg1 = page_select_in;
      st_d.pg2 = st_q.pg1;

      if (st_q.rc != 8'h00) begin
         st_d.rc = st_q.rc - 8'h01;
      end
      if (init_conf_in) begin
         st_d.rc = 8'(`FCS_RECONF_CYC);
      end

      if (st_q.din_v && dec_in_ready_in) begin
         st_d.din_v = 1'b0;
      end

      unique case (st_q.state)
         fcs_pkg::FCS_S_HOLD: begin
            st_d.clk_o = 1'b0;
            st_d.dat   = 8'h00;
            if (st_q.st2) begin
               // Released status starts a fresh sequence.
               st_d.state = fcs_pkg::FCS_S_FETCH;
               st_d.widx  = 6'h00;
               st_d.tick  = 3'h0;
               st_d.pend  = 1'b0;
            end
         end

         fcs_pkg::FCS_S_FETCH: begin
            if (st_q.tick == 3'(`FCS_FETCH_DIV - 1)) begin
               st_d.tick = 3'h0;
               if (!st_q.pend && (st_q.widx < 6'(`FCS_OPT_WORDS))) begin
                  st_d.rd   = 1'b1;
                  st_d.fa   = `FCS_OPT_BASE + {16'h0000, st_q.widx};
                  st_d.pend = 1'b1;
               end
            end else begin
               st_d.tick = st_q.tick + 3'h1;
            end
            if (st_q.pend && flash_valid_in) begin
               st_d.pend = 1'b0;
               st_d.widx = st_q.widx + 6'h01;
            end
            if ((st_q.widx == 6'(`FCS_OPT_WORDS)) && !st_q.pend) begin
               st_d.page  = st_q.pg2;
               st_d.widx  = 6'h00;
               st_d.state = fcs_pkg::FCS_S_APPLY;
            end
         end

         fcs_pkg::FCS_S_APPLY: begin
            st_d.widx = st_q.widx + 6'h01;
            unique case (st_q.widx[1:0])
               2'b01: begin
                  st_d.scheme = mi.rdata[`FCS_OPT_SCHEME_LSB +: 3];
                  st_d.decomp = mi.rdata[`FCS_OPT_DECOMP_BIT];
                  st_d.div    = mi.rdata[`FCS_OPT_DIV_LSB +: 8];
               end
               2'b10: begin
                  st_d.nxt = 22'({mi.rdata, `FCS_PAGE_SHIFT'h0});
               end
               2'b11: begin
                  st_d.left  = 22'({mi.rdata, `FCS_PAGE_SHIFT'h0});
                  st_d.state = fcs_pkg::FCS_S_READY;
               end
               2'b00: begin
               end
            endcase
         end

         fcs_pkg::FCS_S_READY: begin
            if (st_q.st2 && !st_q.dn2) begin
               st_d.state     = fcs_pkg::FCS_S_STREAM;
               st_d.hcnt      = 8'h00;
               st_d.bits      = 5'h00;
               st_d.dat_ok    = 1'b0;
               st_d.last_seen = 1'b0;
               st_d.clk_o     = 1'b0;
            end
         end

         fcs_pkg::FCS_S_STREAM: begin
            if (can_rd) begin
               st_d.rd   = 1'b1;
               st_d.fa   = st_q.nxt;
               st_d.nxt  = st_q.nxt + 22'h1;
               st_d.left = st_q.left - 22'h1;
               st_d.pend = 1'b1;
            end
            if (st_q.pend && flash_valid_in) begin
               st_d.pend = 1'b0;
               if (st_q.decomp) begin
                  st_d.din_v = 1'b1;
                  st_d.din_w = flash_data_in;
               end else begin
                  st_d.sh   = flash_data_in;
                  st_d.bits = 5'h10;
               end
            end
            if (dec_take && dec_out_valid_in) begin
               st_d.sh        = dec_out_word_in;
               st_d.bits      = 5'h10;
               st_d.last_seen = st_q.last_seen | dec_out_last_in;
            end
            if (st_q.hcnt != 8'h00) begin
               st_d.hcnt = st_q.hcnt - 8'h01;
            end else if (st_q.clk_o) begin
               st_d.clk_o  = 1'b0;
               st_d.dat_ok = 1'b0;
               st_d.hcnt   = st_q.div;
            end else if (st_q.dat_ok) begin
               st_d.clk_o = 1'b1;
               st_d.hcnt  = st_q.div;
            end else if (st_q.bits != 5'h00) begin
               // Data is set up a half period ahead of the rising edge.
               st_d.dat    = st_q.sh[7:0] & lane_mask(st_q.scheme);
               st_d.sh     = st_q.sh >> lane_width(st_q.scheme);
               st_d.bits   = st_q.bits - lane_width(st_q.scheme);
               st_d.dat_ok = 1'b1;
               st_d.hcnt   = st_q.div;
            end else if (fin) begin
               st_d.state = fcs_pkg::FCS_S_DONEW;
               st_d.edges = 7'h00;
               st_d.dat   = 8'h00;
            end
            // Otherwise the clock rests low until data arrives.
         end

         fcs_pkg::FCS_S_DONEW: begin
            if (st_q.hcnt != 8'h00) begin
               st_d.hcnt = st_q.hcnt - 8'h01;
            end else begin
               st_d.clk_o = !st_q.clk_o;
               st_d.hcnt  = st_q.div;
               if (!st_q.clk_o) begin
                  st_d.edges = st_q.edges + 7'h01;
               end
            end
            if (st_q.dn2) begin
               st_d.state = fcs_pkg::FCS_S_COMPLETE;
               st_d.clk_o = 1'b0;
               st_d.dat   = 8'hff;
            end else if (st_q.edges == 7'(`FCS_DONE_EDGES)) begin
               st_d.state = fcs_pkg::FCS_S_ERR;
               st_d.clk_o = 1'b0;
               st_d.pc    = 8'(`FCS_ERR_PULSE_CYC);
            end
         end

         fcs_pkg::FCS_S_ERR: begin
            if (st_q.pc == 8'h01) begin
               st_d.state = fcs_pkg::FCS_S_HOLD;
            end
            st_d.pc = st_q.pc - 8'h01;
         end

         fcs_pkg::FCS_S_COMPLETE: begin
            st_d.clk_o = 1'b0;
            st_d.dat   = 8'hff;
         end
      endcase

      // Status low from the target halts and resets the sequence.
      if (!st_q.st2 && (st_q.state != fcs_pkg::FCS_S_HOLD)
          && (st_q.state != fcs_pkg::FCS_S_ERR)) begin
         st_d.state     = fcs_pkg::FCS_S_HOLD;
         st_d.clk_o     = 1'b0;
         st_d.dat       = 8'h00;
         st_d.pend      = 1'b0;
         st_d.din_v     = 1'b0;
         st_d.dat_ok    = 1'b0;
         st_d.bits      = 5'h00;
         st_d.rd        = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign flash_addr_out    = st_q.fa;
   assign flash_rd_out      = st_q.rd;
   assign flash_drive_out   = (st_q.state != fcs_pkg::FCS_S_COMPLETE);
   assign flash_pullup_out  = (st_q.state == fcs_pkg::FCS_S_COMPLETE);
   assign flash_keeper_out  = (st_q.state == fcs_pkg::FCS_S_COMPLETE);

   assign dec_in_valid_out  = st_q.din_v;
   assign dec_in_word_out   = st_q.din_w;
   assign dec_out_ready_out = dec_take;

   assign config_clock_out  = st_q.clk_o;
   assign config_data_out   = st_q.dat;
   assign byte_parallel_mode_out = (st_q.scheme == fcs_pkg::FCS_M_BYTE);

   // Open-drain pins only ever pull low.
   assign status_out        = 1'b0;
   assign status_oe_out     = (st_q.state == fcs_pkg::FCS_S_ERR);
   assign reconf_req_out    = 1'b0;
   assign reconf_req_oe_out = (st_q.rc != 8'h00);

endmodule // fcs_top

`default_nettype wire

// file: tb/fcs_tgt_model.sv
`timescale 1ns/1ps
`default_nettype none

module fcs_tgt_model #(
   parameter int RST_NS = 2000
) (
   // Configuration pins
   input  wire logic        config_clock_in,
   input  wire logic [7:0]  data_in,
   input  wire logic        status_in,
   // Bench control
   input  wire logic [11:0] need_in,
   input  wire logic        restart_in,
   // Target outputs
   output logic             done_out,
   output logic             pull_out
);
   logic [11:0] cnt_q = 12'h000;
   logic [7:0]  cap_q;

   initial begin
      done_out = 1'b0;
      pull_out = 1'b1;
      #300;
      pull_out = 1'b0;
   end

   // The target clears itself while the status line is low.
   always @(posedge config_clock_in or negedge status_in) begin
      if (!status_in) begin
         cnt_q <= 12'h000;
         done_out <= 1'b0;
      end else begin
         cap_q <= data_in;
         cnt_q <= cnt_q + 12'h001;
         if (need_in != 12'h000 && cnt_q + 12'h001 == need_in) begin
            done_out <= 1'b1;
         end
      end
   end

   // A corrupt image pulls the line low; auto restart lets it go later.
   always @(posedge restart_in) begin
      pull_out <= 1'b1;
      #(RST_NS);
      pull_out <= 1'b0;
   end
endmodule // fcs_tgt_model

`default_nettype wire

// file: tb/fcs_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module fcs_chk (
   // Clock and reset
   input wire logic        clk_in,
   input wire logic        rstn_in,
   // Watched pins
   input wire logic [21:0] flash_addr_out,
   input wire logic        flash_rd_out,
   input wire logic        flash_drive_out,
   input wire logic        flash_keeper_out,
   input wire logic        flash_pullup_out,
   input wire logic        config_clock_out,
   input wire logic [7:0]  config_data_out,
   input wire logic        status_in,
   input wire logic        status_oe_out,
   input wire logic        done_in,
   input wire logic        init_conf_in,
   input wire logic        reconf_req_oe_out
);
   logic       fresh_q;
   logic       st_q;
   logic       ck_q;
   logic [6:0] oe_q;
   logic [7:0] ed_q;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   // Trailing zero-data clock edges since the last real unit.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fresh_q <= 1'b1;
         st_q <= 1'b1;
         ck_q <= 1'b0;
         oe_q <= 7'h00;
         ed_q <= 8'h00;
      end else begin
         fresh_q <= (status_in && !st_q) || (fresh_q && !flash_rd_out);
         st_q <= status_in;
         ck_q <= config_clock_out;
         oe_q <= status_oe_out ? oe_q + 7'h01 : 7'h00;
         if (config_clock_out && !ck_q) begin
            ed_q <= (config_data_out != 8'h00) ? 8'h00
                                               : ed_q + {7'h00, ed_q != 8'hff};
         end
      end
   end

   sequence s_halted;
      (!status_in && !status_oe_out) [*5];
   endsequence
   sequence s_req_held;
      reconf_req_oe_out [*8];
   endsequence

   property p_halt;
      s_halted |-> !config_clock_out && config_data_out == 8'h00;
   endproperty
   property p_fetch_base;
      flash_rd_out && fresh_q |-> flash_addr_out == 22'h008000;
   endproperty
   property p_fetch_pace;
      flash_rd_out && flash_addr_out[21:5] == 17'h00400 |=> !flash_rd_out [*3];
   endproperty
   property p_no_start;
      done_in [*6] |-> !$rose(config_clock_out);
   endproperty
   property p_done;
      flash_pullup_out |-> !config_clock_out && config_data_out == 8'hff
                           && flash_keeper_out && !flash_drive_out;
   endproperty
   property p_err_edges;
      $rose(status_oe_out) |-> ed_q >= 8'd64;
   endproperty
   property p_err_len;
      $fell(status_oe_out) |-> oe_q == 7'd40;
   endproperty
   property p_req;
      init_conf_in |=> s_req_held;
   endproperty

   a_halt: assert property (p_halt)
      else $error("clock or data active while status low");
   a_fetch_base: assert property (p_fetch_base)
      else $error("first read after restart not at option base");
   a_fetch_pace: assert property (p_fetch_pace)
      else $error("option reads faster than oscillator pace");
   a_no_start: assert property (p_no_start)
      else $error("clock started while done high");
   a_done: assert property (p_done)
      else $error("pins wrong after completion");
   a_err_edges: assert property (p_err_edges)
      else $error("done error before 64 clock edges");
   a_err_len: assert property (p_err_len)
      else $error("done error pulse length wrong");
   a_req: assert property (p_req)
      else $error("reconfiguration request not pulled low");
endmodule // fcs_chk

bind fcs_top fcs_chk u_chk (
   .clk_in(clk_in), .rstn_in(rstn_in), .flash_addr_out(flash_addr_out),
   .flash_rd_out(flash_rd_out), .flash_drive_out(flash_drive_out),
   .flash_keeper_out(flash_keeper_out), .flash_pullup_out(flash_pullup_out),
   .config_clock_out(config_clock_out), .config_data_out(config_data_out),
   .status_in(status_in), .status_oe_out(status_oe_out), .done_in(done_in),
   .init_conf_in(init_conf_in), .reconf_req_oe_out(reconf_req_oe_out)
);

`default_nettype wire

// file: tb/fcs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module fcs_top_tb;
   logic        clk_in = 1'b0;
   logic        rstn_in = 1'b1;
   logic        flash_valid_in = 1'b0;
   logic        init_conf_in = 1'b0;
   logic        restart = 1'b0;
   logic        ck_prev = 1'b0;
   logic        sel = 1'b0;
   logic [15:0] flash_data_in = 16'h0000;
   logic [2:0]  page_select_in = 3'h0;
   logic [11:0] need = 12'h000;
   logic [21:0] flash_addr_out, exp_start;
   logic [15:0] dec_in_word_out, rnd = 16'hb8f2;
   logic [15:0] opt [32];
   logic [7:0]  config_data_out;
   logic [7:0]  q [$];
   logic [2:0]  scm;
   logic        flash_rd_out, flash_drive_out, flash_pullup_out, pull;
   logic        flash_keeper_out, dec_in_valid_out, dec_out_ready_out;
   logic        config_clock_out, byte_parallel_mode_out, status_out;
   logic        status_oe_out, done_in, reconf_req_out, reconf_req_oe_out;
   int          failures = 0, n_tests = 0, rd_idx = 0, dcnt = 0, n;
   wire logic   status_line = !pull && (status_oe_out ? status_out : 1'b1);
   wire logic   watch = sel ? reconf_req_oe_out : status_oe_out;

   always #12.5 clk_in = ~clk_in;

   fcs_top u_dut (
      .clk_in(clk_in), .rstn_in(rstn_in), .flash_addr_out(flash_addr_out),
      .flash_rd_out(flash_rd_out), .flash_data_in(flash_data_in),
      .flash_valid_in(flash_valid_in), .flash_drive_out(flash_drive_out),
      .flash_pullup_out(flash_pullup_out), .flash_keeper_out(flash_keeper_out),
      .dec_in_valid_out(dec_in_valid_out), .dec_in_word_out(dec_in_word_out),
      .dec_in_ready_in(dec_out_ready_out), .dec_out_valid_in(dec_in_valid_out),
      .dec_out_word_in(dec_in_word_out), .dec_out_last_in(dcnt == 63),
      .dec_out_ready_out(dec_out_ready_out),
      .config_clock_out(config_clock_out), .config_data_out(config_data_out),
      .byte_parallel_mode_out(byte_parallel_mode_out),
      .status_in(status_line), .status_out(status_out),
      .status_oe_out(status_oe_out), .done_in(done_in),
      .page_select_in(page_select_in), .init_conf_in(init_conf_in),
      .reconf_req_out(reconf_req_out), .reconf_req_oe_out(reconf_req_oe_out)
   );

   fcs_tgt_model u_tgt (
      .config_clock_in(config_clock_out), .data_in(config_data_out),
      .status_in(status_line), .need_in(need), .restart_in(restart),
      .done_out(done_in), .pull_out(pull)
   );

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic check(input logic [21:0] seen, input logic [21:0] want);
      n_tests++;
      if (seen !== want) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   // Splits a flash word into the units the link sends, low bits first.
   task automatic push(input logic [15:0] w);
      int b;
      b = (scm > 3'd2) ? 8 : (1 << scm);
      for (int k = 0; k < 16; k += b) begin
         q.push_back(8'((w >> k) & ((16'h0001 << b) - 16'h0001)));
      end
   endtask

   task automatic setup(input logic [2:0] s, input logic dc, input logic [7:0] dv);
      rnd = lfsr(rnd);
      scm = s;
      opt[0] = {4'h0, dv, dc, s};
      for (int p = 0; p < 8; p++) begin
         opt[1 + 2 * p] = 16'h0010 + 16'(p);
         opt[2 + 2 * p] = 16'h0001;
      end
      exp_start = {6'h00, 16'h0010 + {13'h0000, rnd[2:0]}} << 6;
      page_select_in <= rnd[2:0];
      need <= (s > 3'd2) ? 12'd128 : 12'd1024 >> s;
   endtask

   task automatic restart_cfg();
      @(posedge clk_in);
      restart <= 1'b1;
      @(posedge clk_in);
      restart <= 1'b0;
      // A finished image must leave completion before the next wait starts.
      while (flash_pullup_out === 1'b1) begin
         @(posedge clk_in);
      end
   endtask

   task automatic span();
      n = 0;
      while (watch !== 1'b1 && n < 20000) begin
         @(posedge clk_in);
         n++;
      end
      n = 0;
      while (watch === 1'b1 && n < 200) begin
         @(posedge clk_in);
         n++;
      end
   endtask

   task automatic wait_done();
      int t;
      t = 0;
      while (flash_pullup_out !== 1'b1 && t < 40000) begin
         @(posedge clk_in);
         t++;
      end
      @(negedge clk_in);
      check(flash_pullup_out, 1'b1);
      check({config_clock_out, config_data_out}, 9'h0ff);
      check({flash_drive_out, flash_keeper_out}, 2'b01);
      check(byte_parallel_mode_out, scm == 3'd4);
      check(q.size(), 0);
      $display("configuration test done, scheme %0d", scm);
      @(posedge clk_in);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Flash answers one cycle after each read and notes the units due.
   always @(posedge clk_in) begin
      flash_valid_in <= flash_rd_out;
      if (!status_line) begin
         rd_idx = 0;
         q.delete();
      end else if (flash_rd_out) begin
         if (rd_idx < 32) begin
            check(flash_addr_out, 22'h008000 + rd_idx[21:0]);
            flash_data_in <= opt[rd_idx];
         end else begin
            check(flash_addr_out, exp_start + rd_idx[21:0] - 22'd32);
            rnd = lfsr(rnd);
            flash_data_in <= rnd;
            push(rnd);
         end
         rd_idx++;
      end
      // The last flag feeds the design, so its count moves after the edge.
      if (!status_line) begin
         dcnt <= 0;
      end else if (dec_in_valid_out && dec_out_ready_out) begin
         dcnt <= dcnt + 1;
      end
   end

   always @(negedge clk_in) begin
      if (config_clock_out && !ck_prev && q.size() > 0) begin
         check(config_data_out, q.pop_front());
      end
      ck_prev = config_clock_out;
   end

   initial begin
      rstn_in <= 1'b0;
      foreach (opt[k]) opt[k] = 16'h0000;
      setup(3'd4, 1'b0, 8'h00);
      repeat (16) @(posedge clk_in);
      rstn_in <= 1'b1;
      wait_done();
      for (int s = 0; s < 4; s++) begin
         setup(3'(s), s[0], {6'h00, s == 1, 1'b0});
         restart_cfg();
         wait_done();
      end
      setup(3'd3, 1'b0, 8'h00);
      need <= 12'h000;
      restart_cfg();
      span();
      check(n, 40);
      need <= 12'd128;
      wait_done();
      setup(3'd0, 1'b0, 8'h00);
      restart_cfg();
      repeat (600) @(posedge clk_in);
      restart_cfg();
      wait_done();
      @(posedge clk_in);
      init_conf_in <= 1'b1;
      @(posedge clk_in);
      init_conf_in <= 1'b0;
      sel = 1'b1;
      span();
      check(n, 80);
      check({status_out, reconf_req_out}, 2'b00);
      $display("reconfiguration request test done");
      wrap_up();
   end

   initial begin
      #1_000_000;
      failures++;
      $display("watchdog expired at %0t", $time);
      wrap_up();
   end
endmodule // fcs_top_tb

`default_nettype wire
